// *** vcc_checker.sv ***
// Capability register bank with the entry checks and side effects
// that read it. Assumes all request inputs come from core logic on
// mclk, so none is synchronised.
//
// Strobed register access was decided locally.
`default_nettype none
module vcc_checker #(
    parameter logic [63:0] BASIC_CAP = 64'h0080_0000_0000_0000,
    parameter logic [63:0] EXIT_MAP = 64'h8000_0000_0000_0000,
    parameter logic [63:0] ENTRY_MAP = 64'h0000_FFFF_0000_11FF,
    parameter logic [63:0] EXACT_MAP = 64'h0000_FFFF_0000_0000,
    parameter logic [63:0] SEC_EXIT_MAP = 64'h0000_0000_0000_00FF,
    parameter logic [4:0] TIMER_RATE = 5'h05,
    parameter logic [2:0] ACT_STATES = 3'h7,
    parameter logic [2:0] LIST_SCALE = 3'h0,
    parameter logic [7:0] MISC_FLAGS = 8'h7F,
    parameter int TARGET_COUNT = 4,
    parameter logic [31:0] SEG_REVISION = 32'h0000_0000,
    parameter logic [63:0] CR0_ONES = 64'h0000_0000_8000_0021,
    parameter logic [63:0] CR0_ZEROS = 64'h0000_0000_FFFF_FFFF,
    parameter logic [63:0] CR4_ONES = 64'h0000_0000_0000_2000,
    parameter logic [63:0] CR4_ZEROS = 64'h0000_0000_00FF_FFFF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [63:0] reg_rdata,
    // entry check
    input wire logic entry_req,
    input wire logic [31:0] entry_ctls,
    input wire logic [63:0] sec_exit_ctls,
    input wire logic sec_exit_active,
    input wire logic [1:0] activity_state,
    input wire logic inject_soft,
    input wire logic inject_len_zero,
    output logic entry_done,
    output logic entry_fail,
    output logic [4:0] entry_why,
    // preemption countdown
    input wire logic [63:0] timestamp_counter,
    input wire logic tsc_inc,
    input wire logic timer_load,
    input wire logic [31:0] timer_value,
    input wire logic timer_active,
    output logic [31:0] timer_count,
    output logic timer_expired,
    // exits and mode changes
    input wire logic vm_exit,
    input wire logic long_mode_active_flag,
    output logic long_mode_guest,
    input wire logic enter_virtualization_instr,
    input wire logic leave_virtualization_instr,
    output logic trace_enable_clear,
    input wire logic trace_ctl_wr,
    output logic gp_fault,
    input wire logic model_register_read_instr,
    input wire logic [11:0] model_read_index,
    input wire logic system_management_mode,
    output logic model_read_refused,
    input wire logic monitor_ctl_wr,
    input wire logic [63:0] monitor_ctl_wdata,
    output logic monitor_block_bit,
    output logic mgmt_int_unblock,
    input wire logic structure_write_instr,
    input wire logic write_exit_info,
    output logic struct_write_refused
);
    import vcc_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // a count above 256 cannot be encoded in bits 24:16
    if (TARGET_COUNT < 0 || TARGET_COUNT > MAX_TARGETS) begin : g_bad
        $error("target count out of range");
    end

    // ------------------------------------------------------------
    // constant register images
    // ------------------------------------------------------------
    // exact map only exists when basic bit 55 is set
    localparam logic HAS_EXACT = BASIC_CAP[BASIC_EXACT_BIT];
    // secondary exit map only exists with activate-secondary allowed
    localparam logic HAS_SEC = EXIT_MAP[EXIT_SEC_ACT_BIT];
    // default-one bits are forced so the image can never lie
    localparam logic [63:0] ENTRY_IMG = ENTRY_MAP | DEFAULT_ONE_MASK;
    localparam logic [63:0] EXACT_IMG = HAS_EXACT ? EXACT_MAP : '0;
    localparam logic [63:0] SEC_IMG = HAS_SEC ? SEC_EXIT_MAP : '0;
    // bit 24 alone encodes 256, otherwise 23:16 hold the count
    localparam logic [8:0] TGT_FIELD = 9'(TARGET_COUNT);
    // 63:32 rev, 31 zero, 30:28 flags, 27:25 scale, 24:16 targets,
    // 15:14 flags, 13:9 zero, 8:6 states, 5 flag, 4:0 rate
    localparam logic [63:0] MISC_IMG = {SEG_REVISION, 1'b0,
        MISC_FLAGS[6:4], LIST_SCALE, TGT_FIELD, MISC_FLAGS[1:0], 5'h00,
        ACT_STATES, MISC_FLAGS[2], TIMER_RATE} & ~MISC_RSVD_MASK;
    // fixed-one map masked by fixed-zero map: never 1 over 0
    localparam logic [63:0] CR0_ONES_IMG = CR0_ONES & CR0_ZEROS;
    localparam logic [63:0] CR4_ONES_IMG = CR4_ONES & CR4_ZEROS;
    // governing map picked once from bit 55
    localparam logic [63:0] GOV_MAP = HAS_EXACT ? EXACT_IMG
        : ENTRY_IMG;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [63:0] rdata; // read answer, one cycle only
        logic done; // entry check finished
        logic fail; // entry refused
        logic [4:0] why; // refusal causes
        logic [31:0] timer; // preemption countdown
        logic tsc_prev; // last seen timestamp bit X
        logic expired; // countdown reached zero
        logic lm_guest; // long-mode guest control image
        logic in_virt; // inside virtualisation
        logic trace_clr; // trace enable clear pulse
        logic gp; // fault pulse on trace writes
        logic rd_refused; // management base read refused
        logic mon_bit; // monitor control bit 2
        logic unblock; // management interrupts unblocked
        logic wr_refused; // exit information write refused
    } vcc_state_s;

    vcc_state_s st; // registered state
    vcc_state_s next_st; // next state
    logic [63:0] read_mux; // decoded register image
    logic [4:0] cause; // per-check failure causes
    logic tsc_bit; // timestamp bit selected by rate
    logic tick; // one countdown step

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // writes never reach this mux, so only the check status entry can change
    always_comb begin
        case (reg_addr)
            OFS_ENTRY_MAP: read_mux = ENTRY_IMG;
            OFS_MISC: read_mux = MISC_IMG;
            OFS_CR0_ONES: read_mux = CR0_ONES_IMG;
            OFS_CR0_ZEROS: read_mux = CR0_ZEROS;
            OFS_CR4_ONES: read_mux = CR4_ONES_IMG;
            OFS_CR4_ZEROS: read_mux = CR4_ZEROS;
            OFS_EXACT_MAP: read_mux = EXACT_IMG;
            OFS_SEC_EXIT: read_mux = SEC_IMG;
            OFS_CHECK_STATUS: read_mux = {st.timer, 24'h0, st.in_virt,
                st.fail, 1'b0, st.why};
            default: read_mux = RDATA_RESET; // unmapped reads zero
        endcase
    end

    // ------------------------------------------------------------
    // entry checks
    // ------------------------------------------------------------
    // each cause is one bit so software can see why entry failed
    always_comb begin
        // allowed-0 map: set bit needs control one
        cause[0] = |(GOV_MAP[31:0] & ~entry_ctls);
        // allowed-1 map: control one needs upper bit
        cause[1] = |(entry_ctls & ~GOV_MAP[63:32]);
        // secondary exit controls count only when activated
        cause[2] = sec_exit_active & |(sec_exit_ctls & ~SEC_IMG);
        // activity state 0 always allowed
        cause[3] = (activity_state != 2'h0) &&
            !MISC_IMG[MISC_ACT_LSB + 32'(activity_state) - 1];
        // zero-length software injection gated by bit 30
        cause[4] = inject_soft & inject_len_zero
            & ~MISC_IMG[MISC_INJ0_BIT];
    end

    // ------------------------------------------------------------
    // countdown step
    // ------------------------------------------------------------
    // only a counter increment that flips bit X counts
    always_comb begin
        tsc_bit = timestamp_counter[TIMER_RATE];
        tick = timer_active & tsc_inc & (tsc_bit != st.tsc_prev)
            & (st.timer != TIMER_RESET);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // read data stand one cycle, zero otherwise
        next_st.rdata = reg_rd ? read_mux : RDATA_RESET;
        next_st.done = entry_req;
        if (entry_req) begin
            next_st.fail = |cause;
            next_st.why = cause;
        end
        next_st.tsc_prev = tsc_bit;
        next_st.expired = 1'b0;
        // a load beats a step in the same cycle
        if (timer_load) begin
            next_st.timer = timer_value;
        end else if (tick) begin
            next_st.timer = st.timer - 32'h1;
            next_st.expired = (st.timer == 32'h1);
        end
        // copy the mode flag only when bit 5 says so
        if (vm_exit && MISC_IMG[MISC_LM_BIT]) begin
            next_st.lm_guest = long_mode_active_flag;
        end
        next_st.trace_clr = 1'b0;
        next_st.gp = 1'b0;
        next_st.unblock = 1'b0;
        if (enter_virtualization_instr) begin
            next_st.in_virt = 1'b1;
            next_st.trace_clr = ~MISC_IMG[MISC_TRACE_BIT];
        end else if (leave_virtualization_instr) begin
            next_st.in_virt = 1'b0;
            next_st.unblock = ~st.mon_bit;
        end
        if (trace_ctl_wr && st.in_virt) begin
            next_st.gp = ~MISC_IMG[MISC_TRACE_BIT];
        end
        // base register read inside management mode
        next_st.rd_refused = model_register_read_instr
            && system_management_mode && model_read_index == SMBASE_INDEX
            && !MISC_IMG[MISC_SMBASE_BIT];
        // bit 2 sticks at zero unless bit 28 allows it
        if (monitor_ctl_wr) begin
            next_st.mon_bit = monitor_ctl_wdata[MONITOR_CTL_BIT]
                & MISC_IMG[MISC_MONITOR_BIT];
        end
        next_st.wr_refused = structure_write_instr & write_exit_info
            & ~MISC_IMG[MISC_STRUCTURE_WRITE_INSTR_BIT];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign entry_done = st.done;
    assign entry_fail = st.fail;
    assign entry_why = st.why;
    assign timer_count = st.timer;
    assign timer_expired = st.expired;
    assign long_mode_guest = st.lm_guest;
    assign trace_enable_clear = st.trace_clr;
    assign gp_fault = st.gp;
    assign model_read_refused = st.rd_refused;
    assign monitor_block_bit = st.mon_bit;
    assign mgmt_int_unblock = st.unblock;
    assign struct_write_refused = st.wr_refused;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_sec_exit_fail: assert property (@(posedge mclk) disable iff (sys_rst)
        entry_req && sec_exit_active && |(sec_exit_ctls & ~SEC_IMG)
        |=> entry_fail && entry_why[2])
        else $error("secondary exit violation not refused");
    chk_sec_absent: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == OFS_SEC_EXIT && !HAS_SEC |=> reg_rdata == 0)
        else $error("absent secondary map read nonzero");
    chk_default_one: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == OFS_ENTRY_MAP
        |=> reg_rdata[8:0] == 9'h1FF && reg_rdata[12])
        else $error("default-one bits not read as one");
    chk_exact_absent: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == OFS_EXACT_MAP && !HAS_EXACT
        |=> reg_rdata == 0)
        else $error("unsupported exact map read nonzero");
    chk_timer_step: assert property (@(posedge mclk) disable iff (sys_rst)
        tick && !timer_load |=> timer_count == $past(timer_count) - 1)
        else $error("countdown missed a step");
    chk_lm_copy: assert property (@(posedge mclk) disable iff (sys_rst)
        vm_exit && MISC_IMG[MISC_LM_BIT]
        |=> long_mode_guest == $past(long_mode_active_flag))
        else $error("long mode flag not copied");
    chk_trace_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        enter_virtualization_instr && !MISC_IMG[MISC_TRACE_BIT]
        ##1 !enter_virtualization_instr |-> trace_enable_clear ##1
        !trace_enable_clear)
        else $error("trace clear pulse wrong");
    chk_write_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
        structure_write_instr && write_exit_info
        |=> struct_write_refused == !MISC_IMG[MISC_STRUCTURE_WRITE_INSTR_BIT])
        else $error("exit info write gating wrong");
    chk_fixed_pair: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == OFS_CR0_ONES
        |=> (reg_rdata & ~CR0_ZEROS) == 0)
        else $error("fixed one over fixed zero");
    chk_target_count: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && reg_addr == OFS_MISC
        |=> reg_rdata[24] == (reg_rdata[23:16] == 8'h00))
        else $error("target count encoding wrong");
    chk_read_const: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && reg_addr == OFS_MISC ##1 reg_rd && reg_addr == OFS_MISC
        |=> reg_rdata == MISC_IMG)
        else $error("write altered a capability register");
endmodule
`default_nettype wire

// *** vcc_pkg.sv ***
// Constants for the virtualisation capability register bank and checker.
// Assumes one core clock and a plain indexed register port.
`default_nettype none
package vcc_pkg;
    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_ENTRY_MAP = 12'h484;
    localparam logic [11:0] OFS_MISC = 12'h485;
    localparam logic [11:0] OFS_CR0_ONES = 12'h486;
    localparam logic [11:0] OFS_CR0_ZEROS = 12'h487;
    localparam logic [11:0] OFS_CR4_ONES = 12'h488;
    localparam logic [11:0] OFS_CR4_ZEROS = 12'h489;
    localparam logic [11:0] OFS_EXACT_MAP = 12'h490;
    localparam logic [11:0] OFS_SEC_EXIT = 12'h493;
    localparam logic [11:0] OFS_CHECK_STATUS = 12'h4F0;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam logic [63:0] DEFAULT_ONE_MASK = 64'h0000_0000_0000_11FF;
    localparam logic [63:0] MISC_RSVD_MASK = 64'h0000_0000_8000_3E00;
    localparam int BASIC_EXACT_BIT = 55;
    localparam int EXIT_SEC_ACT_BIT = 63;
    localparam int MISC_LM_BIT = 5;
    localparam int MISC_ACT_LSB = 6;
    localparam int MISC_TRACE_BIT = 14;
    localparam int MISC_SMBASE_BIT = 15;
    localparam int MISC_TGT_LSB = 16;
    localparam int MISC_TGT_MSB_BIT = 24;
    localparam int MISC_MONITOR_BIT = 28;
    localparam int MISC_STRUCTURE_WRITE_INSTR_BIT = 29;
    localparam int MISC_INJ0_BIT = 30;
    localparam int MISC_REV_LSB = 32;
    localparam int MONITOR_CTL_BIT = 2;
    localparam logic [11:0] SMBASE_INDEX = 12'h09E;
    localparam int MAX_TARGETS = 256;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [63:0] RDATA_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// *** vcc_tb.sv ***
// self-checking bench for the capability bank and its entry checks
// assumes vcc_pkg and vcc_checker are compiled first; one 100 MHz clock
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vcc_pkg::*;
    // ----------------------------------------------------------
    // stimulus, shared by both instances
    // ----------------------------------------------------------
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [11:0] model_read_index = 12'h000;
    logic [63:0] reg_wdata = 64'h0, sec_exit_ctls = 64'h0;
    logic [63:0] timestamp_counter = 64'h0, monitor_ctl_wdata = 64'h0;
    logic [31:0] entry_ctls = 32'h0, timer_value = 32'h0;
    logic [1:0] activity_state = 2'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, entry_req = 1'b0;
    logic sec_exit_active = 1'b0, inject_soft = 1'b0;
    logic inject_len_zero = 1'b0, tsc_inc = 1'b0, timer_load = 1'b0;
    logic timer_active = 1'b0, vm_exit = 1'b0;
    logic long_mode_active_flag = 1'b0, enter_virtualization_instr = 1'b0;
    logic leave_virtualization_instr = 1'b0, trace_ctl_wr = 1'b0;
    logic model_register_read_instr = 1'b0, system_management_mode = 1'b0;
    logic monitor_ctl_wr = 1'b0, structure_write_instr = 1'b0;
    logic write_exit_info = 1'b0;
    // ----------------------------------------------------------
    // results: plain names for the full-featured instance,
    // b_ names for the stripped one (no exact map, no flags)
    // ----------------------------------------------------------
    logic [63:0] reg_rdata, b_rdata;
    logic [31:0] timer_count, b_timer_count;
    logic [4:0] entry_why, b_entry_why;
    logic entry_done, entry_fail, timer_expired, long_mode_guest;
    logic trace_enable_clear, gp_fault, model_read_refused;
    logic monitor_block_bit, mgmt_int_unblock, struct_write_refused;
    logic b_done, b_fail, b_expired, b_lm, b_trace, b_gp, b_refused;
    logic b_block, b_unblock, b_swr;
    int num_errors = 0;
    int checked = 0;
    // register table: index, image on dut, image on dut_b
    logic [11:0] ra [9] = '{OFS_ENTRY_MAP, OFS_MISC, OFS_CR0_ONES,
        OFS_CR0_ZEROS, OFS_CR4_ONES, OFS_CR4_ZEROS, OFS_EXACT_MAP,
        OFS_SEC_EXIT, 12'h4A0};
    logic [63:0] ea [9] = '{64'h0000_FFFF_0000_11FF, 64'h0000_0000_7004_C1E5,
        64'h8000_0021, 64'hFFFF_FFFF, 64'h2000, 64'h00FF_FFFF,
        64'h0000_FFFF_0000_0000, 64'hFF, 64'h0};
    logic [63:0] eb [9] = '{64'h0000_FFFF_0000_11FF, 64'h0000_0000_0100_0005,
        64'h8000_0021, 64'hFFFF_FFFF, 64'h2000, 64'h00FF_FFFF,
        64'h0, 64'h0, 64'h0};

    vcc_checker dut (.*);
    // stripped instance: every refusal path of the checks is live here
    vcc_checker #(.BASIC_CAP(64'h0), .EXIT_MAP(64'h0), .ACT_STATES(3'h0),
        .MISC_FLAGS(8'h00), .TARGET_COUNT(256)) dut_b (.reg_rdata(b_rdata),
        .entry_done(b_done), .entry_fail(b_fail), .entry_why(b_entry_why),
        .timer_count(b_timer_count), .timer_expired(b_expired),
        .long_mode_guest(b_lm), .trace_enable_clear(b_trace),
        .gp_fault(b_gp), .model_read_refused(b_refused),
        .monitor_block_bit(b_block), .mgmt_int_unblock(b_unblock),
        .struct_write_refused(b_swr), .*);

    // ----------------------------------------------------------
    // clock, compare and closing
    // ----------------------------------------------------------
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one read; data only in the cycle after the strobe
    task automatic reg_read(input int i);
        @(posedge mclk);
        reg_addr <= ra[i];
        reg_rd <= 1'b1;
        // a write just before ends here, read follows with no gap
        reg_wr <= 1'b0;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata dut", ea[i], reg_rdata);
        chk("rdata dut_b", eb[i], b_rdata);
        @(posedge mclk);
        #1;
        chk("rdata idle", 64'h0, reg_rdata | b_rdata);
    endtask
    // the eight capability registers and one unmapped index, then each written with all-ones and read back at once
    task automatic test_regs;
        for (int i = 0; i < 9; i++) begin
            reg_read(i);
        end
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            reg_addr <= ra[i];
            reg_wdata <= 64'hFFFF_FFFF_FFFF_FFFF;
            reg_wr <= 1'b1;
            reg_read(i);
        end
    endtask
    // one entry attempt on both instances; expected why codes given
    task automatic entry(input logic [31:0] c, input logic [63:0] s,
                         input logic sa, input logic [1:0] st,
                         input logic inj, input logic [4:0] wa,
                         input logic [4:0] wb);
        @(posedge mclk);
        entry_req <= 1'b1;
        entry_ctls <= c;
        sec_exit_ctls <= s;
        sec_exit_active <= sa;
        activity_state <= st;
        inject_soft <= inj;
        inject_len_zero <= inj;
        @(posedge mclk);
        entry_req <= 1'b0;
        #1;
        chk("entry done", 64'h3, {b_done, entry_done});
        chk("entry dut", {wa != 5'h0, wa}, {entry_fail, entry_why});
        chk("entry dut_b", {wb != 5'h0, wb}, {b_fail, b_entry_why});
    endtask
    task automatic test_entry;
        entry(32'h0, 64'h0, 1'b0, 2'h0, 1'b0, 5'h00, 5'h01);
        entry(32'h11FF, 64'h0, 1'b0, 2'h0, 1'b0, 5'h00, 5'h00);
        entry(32'h1_11FF, 64'h0, 1'b0, 2'h0, 1'b0, 5'h02, 5'h02);
        entry(32'h11FF, 64'h100, 1'b1, 2'h0, 1'b0, 5'h04, 5'h04);
        entry(32'h11FF, 64'h100, 1'b0, 2'h0, 1'b0, 5'h00, 5'h00);
        entry(32'h11FF, 64'h80, 1'b1, 2'h0, 1'b0, 5'h00, 5'h04);
        for (int st = 1; st < 4; st++) begin
            entry(32'h11FF, 64'h0, 1'b0, st[1:0], 1'b0, 5'h00, 5'h08);
        end
        entry(32'h11FF, 64'h0, 1'b0, 2'h0, 1'b1, 5'h00, 5'h10);
    endtask
    // countdown keyed to timestamp bit five on both instances
    task automatic test_timer;
        int pulses;
        pulses = 0;
        @(posedge mclk);
        timer_load <= 1'b1;
        timer_value <= 32'h3;
        @(posedge mclk);
        timer_load <= 1'b0;
        tsc_inc <= 1'b1;
        // bit five toggles but the timer is not active
        repeat (3) begin
            timestamp_counter <= timestamp_counter + 64'h20;
            @(posedge mclk);
        end
        timer_active <= 1'b1;
        // active, but low bits only: bit five stays put
        repeat (3) begin
            timestamp_counter <= timestamp_counter + 64'h1;
            @(posedge mclk);
        end
        #1;
        chk("timer held", {32'h3, 32'h3}, {timer_count, b_timer_count});
        repeat (6) begin
            timestamp_counter <= timestamp_counter + 64'h20;
            @(posedge mclk);
            #1;
            pulses += int'(timer_expired) + int'(b_expired);
        end
        chk("timer end", 64'h0, {timer_count, b_timer_count});
        chk("timer pulses", 64'h2, 64'(pulses));
        timer_active <= 1'b0;
    endtask
    // one side-effect pulse, result visible after the next edge
    task automatic fire(input int k);
        @(posedge mclk);
        case (k)
            0: vm_exit <= 1'b1;
            1: enter_virtualization_instr <= 1'b1;
            2: trace_ctl_wr <= 1'b1;
            3: begin
                model_register_read_instr <= 1'b1;
                model_read_index <= SMBASE_INDEX;
                system_management_mode <= 1'b1;
            end
            4: begin
                monitor_ctl_wr <= 1'b1;
                monitor_ctl_wdata <= 64'h4;
            end
            5: leave_virtualization_instr <= 1'b1;
            default: begin
                structure_write_instr <= 1'b1;
                write_exit_info <= 1'b1;
            end
        endcase
        @(posedge mclk);
        vm_exit <= 1'b0;
        enter_virtualization_instr <= 1'b0;
        trace_ctl_wr <= 1'b0;
        model_register_read_instr <= 1'b0;
        monitor_ctl_wr <= 1'b0;
        leave_virtualization_instr <= 1'b0;
        structure_write_instr <= 1'b0;
        #1;
    endtask
    task automatic test_side;
        long_mode_active_flag <= 1'b1;
        fire(0);
        chk("lm guest", 64'h2, {long_mode_guest, b_lm});
        fire(1);
        chk("trace clear", 64'h1, {trace_enable_clear, b_trace});
        fire(2);
        chk("gp inside", 64'h1, {gp_fault, b_gp});
        fire(3);
        chk("base read", 64'h1, {model_read_refused, b_refused});
        fire(4);
        chk("block bit", 64'h2, {monitor_block_bit, b_block});
        fire(5);
        chk("unblock", 64'h1, {mgmt_int_unblock, b_unblock});
        fire(2);
        chk("gp outside", 64'h0, {gp_fault, b_gp});
        fire(6);
        chk("struct write", 64'h1, {struct_write_refused, b_swr});
    endtask

    // ----------------------------------------------------------
    // main sequence and watchdog (run needs well under 20 us)
    // ----------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("reset outs", 64'h0, {reg_rdata, entry_done, entry_fail,
            timer_count, b_done, b_fail});
        test_regs();
        test_entry();
        test_timer();
        test_side();
        end_of_test();
    end
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
